// File: design/bridge_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts for the bus share bridge
// Assumes: Host addresses are word addresses, bits 23..1
// Notes:   Shared by the bridge end and the host end
`ifndef BRIDGE_CONSTS_SVH
`define BRIDGE_CONSTS_SVH

`define BRG_REGION_CODE   8'h02
`define BRG_REGION_HI     23
`define BRG_REGION_LO     16
`define BRG_SPACE_BIT     15
`define BRG_DMEM_AW       14
`define BRG_DATA_W        16
`define BRG_HADDR_W       23
`define BRG_ACK_WAIT      2
`define BRG_MON_W         5

`define TX_REQ_BIT        0
`define TX_BUFEN_BIT      1
`define RX_GRANT_BIT      0
`define RX_REQ_BIT        1
`define RX_BUFEN_BIT      2
`define RX_MON_LO         3
`define TX_RESET          2'h0

`define HREG_AW           3
`define HREG_CMD          3'h0
`define HREG_MADDR        3'h1
`define HREG_WDATA        3'h2
`define HREG_RDATA        3'h3
`define HREG_STATUS       3'h4

`define CMD_ACQUIRE       2'h0
`define CMD_RELEASE       2'h1
`define CMD_MEM_WRITE     2'h2
`define CMD_MEM_READ      2'h3

`define ST_BUSY_BIT       0
`define ST_GRANTED_BIT    1
`define ST_ERROR_BIT      2
`define ST_FIFO_LO        3
`define RBUF_DEPTH        2

`endif

// File: design/bridge_pkg.sv
// Purpose: Types shared by the two ends of the bus share bridge
// Assumes: Constants live in bridge_consts.svh
// Notes:   Types only
package bridge_pkg;

	typedef enum {
		STEP_IDLE,
		STEP_SETREQ,
		STEP_POLLGRANT,
		STEP_SETEN,
		STEP_MEM,
		STEP_CLREN,
		STEP_CLRREQ,
		STEP_POLLFREE
	} host_step_t;

	typedef logic [15:0] word_t;

endpackage : bridge_pkg

// File: design/host_bus_if.sv
// Purpose: Asynchronous host bus between host end and bridge end
// Assumes: One clock; both ends sample on mclk
// Notes:   Data lines split into two directions with enables
`timescale 1ns/100ps
interface host_bus_if;
	logic [23:1] addr;
	logic [15:0] dataToDev;
	logic        dataToDevOe;
	logic [15:0] dataFromDev;
	logic        dataFromDevOe;
	logic        readWrite;
	logic        addrStrobeN;
	logic        lowerByteStrobeN;
	logic        upperByteStrobeN;
	logic        transferAckN;

	modport host (
		output addr, dataToDev, dataToDevOe, readWrite, addrStrobeN,
		output lowerByteStrobeN, upperByteStrobeN,
		input  dataFromDev, dataFromDevOe, transferAckN
	);
	modport bridge (
		input  addr, dataToDev, dataToDevOe, readWrite, addrStrobeN,
		input  lowerByteStrobeN, upperByteStrobeN,
		output dataFromDev, dataFromDevOe, transferAckN
	);
endinterface : host_bus_if

// File: design/host_dsp_bus_share_bridge.sv
// Purpose: Glue that lets the host borrow the processor's data memory bus
// Assumes: Host bus and memory data are same-clock logic; grant and monitors are pins
// Notes:   Transmit register holds request and address buffer enable
`timescale 1ns/100ps
`include "bridge_consts.svh"
module host_dsp_bus_share_bridge import bridge_pkg::*; #(
	parameter int ACK_WAIT = `BRG_ACK_WAIT,
	parameter int MON_W    = `BRG_MON_W
) (
	input  wire logic                 mclk,
	input  wire logic                 rst,
	host_bus_if.bridge                hbus,
	output wire logic                 busRequestN,
	input  wire logic                 busGrantN,
	input  wire logic [MON_W-1:0]     monitorLevels,
	output wire logic [13:0]          dmemAddr,
	output wire logic                 dmemAddrOe,
	output wire logic                 dmemSelectN,
	output wire logic                 dmemWriteStrobeN,
	output wire logic                 dmemWriteStrobeOe,
	input  wire logic [15:0]          dmemDataIn,
	output wire logic [15:0]          dmemDataOut,
	output wire logic                 dmemDataOe
);

	localparam int SW = MON_W + 1;

	// Pin synchronisers: grant in bit 0, monitors above
	logic [SW-1:0] pinRaw;
	logic [SW-1:0] syncA_reg;
	logic [SW-1:0] syncB_reg;
	logic [SW-1:0] syncC_reg;
	logic [SW-1:0] pinStable_reg;

	assign pinRaw = {monitorLevels, busGrantN};

	genvar gi;
	generate
		for (gi = 0; gi < SW; gi++) begin : g_sync
			always_ff @(posedge mclk) begin
				if (rst) begin
					syncA_reg[gi]     <= 1'b1;
					syncB_reg[gi]     <= 1'b1;
					syncC_reg[gi]     <= 1'b1;
					pinStable_reg[gi] <= 1'b1;
				end else begin
					syncA_reg[gi] <= pinRaw[gi];
					syncB_reg[gi] <= syncA_reg[gi];
					syncC_reg[gi] <= syncB_reg[gi];
					if (syncB_reg[gi] == syncC_reg[gi]) begin
						pinStable_reg[gi] <= syncC_reg[gi];
					end
				end
			end
		end
	endgenerate

	logic grantN;
	assign grantN = pinStable_reg[0]; // Grant arrives even while halted

	// Address decode
	logic regionHit;
	logic regionDecodeN;
	logic registerSpaceSelect;
	logic accessActive;
	logic regWrite;
	logic regRead;
	logic memAccess;

	assign regionHit = (hbus.addr[`BRG_REGION_HI:`BRG_REGION_LO] == `BRG_REGION_CODE);
	assign regionDecodeN = ~regionHit;
	assign registerSpaceSelect = hbus.addr[`BRG_SPACE_BIT];
	assign accessActive = ~hbus.addrStrobeN & ~regionDecodeN;
	assign regWrite = accessActive & registerSpaceSelect & ~hbus.readWrite;
	assign regRead = accessActive & registerSpaceSelect & hbus.readWrite;
	assign memAccess = accessActive & ~registerSpaceSelect;

	// Acknowledge wait counter
	localparam int CW = $clog2(ACK_WAIT + 2);
	localparam logic [CW-1:0] ACK_AT = CW'(ACK_WAIT);
	logic [CW-1:0] waitCnt_reg;
	logic [CW-1:0] waitCnt_next;
	logic          ackNow;

	assign ackNow = accessActive & (waitCnt_reg == ACK_AT);

	always_comb begin
		waitCnt_next = waitCnt_reg;
		if (!accessActive) begin
			waitCnt_next = '0;
		end else if (waitCnt_reg != ACK_AT) begin
			waitCnt_next = waitCnt_reg + CW'(1);
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			waitCnt_reg <= '0;
		end else begin
			waitCnt_reg <= waitCnt_next;
		end
	end

	assign hbus.transferAckN = ~ackNow;

	// Transmit control register
	logic reqBit_reg;
	logic reqBit_next;
	logic bufEn_reg;
	logic bufEn_next;
	logic txLoad;

	localparam logic [1:0] TX_RST = `TX_RESET;

	assign txLoad = regWrite & ackNow & ~hbus.lowerByteStrobeN;

	always_comb begin
		reqBit_next = reqBit_reg;
		bufEn_next = bufEn_reg;
		if (txLoad) begin
			reqBit_next = hbus.dataToDev[`TX_REQ_BIT];
			bufEn_next = hbus.dataToDev[`TX_BUFEN_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			reqBit_reg <= TX_RST[`TX_REQ_BIT];
			bufEn_reg <= TX_RST[`TX_BUFEN_BIT];
		end else begin
			reqBit_reg <= reqBit_next;
			bufEn_reg <= bufEn_next;
		end
	end

	assign busRequestN = ~reqBit_reg;

	// Buffer paths toward both buses
	logic [15:0] hostRd_reg;
	logic [15:0] hostRd_next;
	logic        hostRdOe_reg;
	logic        hostRdOe_next;
	logic [13:0] dAddr_reg;
	logic [13:0] dAddr_next;
	logic        dAddrOe_reg;
	logic        dAddrOe_next;
	logic        dSelN_reg;
	logic        dSelN_next;
	logic        dWrN_reg;
	logic        dWrN_next;
	logic        dWrOe_reg;
	logic        dWrOe_next;
	logic [15:0] dOut_reg;
	logic [15:0] dOut_next;
	logic        dOe_reg;
	logic        dOe_next;
	logic [15:0] rxWord;

	always_comb begin
		rxWord = '0;
		rxWord[`RX_GRANT_BIT] = grantN;
		rxWord[`RX_REQ_BIT] = reqBit_reg;
		rxWord[`RX_BUFEN_BIT] = bufEn_reg;
		rxWord[`RX_MON_LO +: MON_W] = pinStable_reg[SW-1:1];
	end

	always_comb begin
		hostRd_next = hostRd_reg;
		hostRdOe_next = 1'b0;
		if (regRead) begin
			hostRd_next = rxWord;
			hostRdOe_next = 1'b1;
		end else if (memAccess && hbus.readWrite) begin
			hostRd_next = dmemDataIn;
			hostRdOe_next = 1'b1;
		end
		dAddrOe_next = bufEn_reg;
		dAddr_next = hbus.addr[`BRG_DMEM_AW:1];
		dSelN_next = ~(bufEn_reg & memAccess);
		dWrOe_next = bufEn_reg | ~grantN;
		dWrN_next = ~(bufEn_reg & memAccess & ~hbus.readWrite);
		dOe_next = memAccess & ~hbus.readWrite;
		dOut_next = hbus.dataToDev;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			hostRd_reg <= '0;
			hostRdOe_reg <= 1'b0;
			dAddr_reg <= '0;
			dAddrOe_reg <= 1'b0;
			dSelN_reg <= 1'b1;
			dWrN_reg <= 1'b1;
			dWrOe_reg <= 1'b0;
			dOut_reg <= '0;
			dOe_reg <= 1'b0;
		end else begin
			hostRd_reg <= hostRd_next;
			hostRdOe_reg <= hostRdOe_next;
			dAddr_reg <= dAddr_next;
			dAddrOe_reg <= dAddrOe_next;
			dSelN_reg <= dSelN_next;
			dWrN_reg <= dWrN_next;
			dWrOe_reg <= dWrOe_next;
			dOut_reg <= dOut_next;
			dOe_reg <= dOe_next;
		end
	end

	assign hbus.dataFromDev = hostRd_reg;
	assign hbus.dataFromDevOe = hostRdOe_reg;
	assign dmemAddr = dAddr_reg;
	assign dmemAddrOe = dAddrOe_reg;
	assign dmemSelectN = dSelN_reg;
	assign dmemWriteStrobeN = dWrN_reg;
	assign dmemWriteStrobeOe = dWrOe_reg;
	assign dmemDataOut = dOut_reg;
	assign dmemDataOe = dOe_reg;

endmodule : host_dsp_bus_share_bridge

// File: design/host_bus_master.sv
// Purpose: Host end: runs request, grant polling and memory cycles
// Assumes: Same clock as the bridge; ack sampled directly
// Notes:   Two-entry buffer holds read words until software takes them
//
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "bridge_consts.svh"
module host_bus_master import bridge_pkg::*; #(
	parameter int RB_W     = `BRG_DATA_W,
	parameter int RB_DEPTH = `RBUF_DEPTH
) (
	input  wire logic                 mclk,
	input  wire logic                 rst,
	host_bus_if.host                  hbus,
	input  wire logic [`HREG_AW-1:0]  regAddr,
	input  wire logic [15:0]          regWrData,
	input  wire logic                 regWrStb,
	input  wire logic                 regRdStb,
	output wire logic [15:0]          regRdData
);

	localparam logic [22:0] REG_ADDR = {`BRG_REGION_CODE, 1'b1, 14'h0000};
	localparam int PW = $clog2(RB_DEPTH);

	host_step_t  step_reg;
	host_step_t  step_next;
	logic        cycOn_reg;
	logic        cycOn_next;
	logic        granted_reg;
	logic        granted_next;
	logic        error_reg;
	logic        error_next;
	logic        memRead_reg;
	logic        memRead_next;
	logic [13:0] mAddr_reg;
	logic [13:0] mAddr_next;
	logic [15:0] wData_reg;
	logic [15:0] wData_next;
	logic [22:0] hAddr_reg;
	logic [22:0] hAddr_next;
	logic        hRw_reg;
	logic        hRw_next;
	logic        hAsN_reg;
	logic        hAsN_next;
	logic [15:0] hData_reg;
	logic [15:0] hData_next;
	logic        hDataOe_reg;
	logic        hDataOe_next;
	logic [15:0] rdData_reg;
	logic [15:0] rdData_next;

	// Read buffer
	logic [RB_W-1:0] rbMem [RB_DEPTH];
	logic [PW-1:0]   rbWr_reg;
	logic [PW-1:0]   rbRd_reg;
	logic [PW:0]     rbCnt_reg;
	logic            rbInReady;
	logic            rbOutValid;
	logic            rbPush;
	logic            rbPop;

	assign rbInReady = (rbCnt_reg != (PW+1)'(RB_DEPTH));
	assign rbOutValid = (rbCnt_reg != '0);
	assign rbPop = regRdStb & (regAddr == `HREG_RDATA) & rbOutValid;

	always_ff @(posedge mclk) begin
		if (rst) begin
			rbWr_reg <= '0;
			rbRd_reg <= '0;
			rbCnt_reg <= '0;
		end else begin
			if (rbPush) begin
				rbMem[rbWr_reg] <= hbus.dataFromDev[RB_W-1:0];
				rbWr_reg <= (rbWr_reg == PW'(RB_DEPTH-1)) ? '0 : rbWr_reg + PW'(1);
			end
			if (rbPop) begin
				rbRd_reg <= (rbRd_reg == PW'(RB_DEPTH-1)) ? '0 : rbRd_reg + PW'(1);
			end
			rbCnt_reg <= rbCnt_reg + (PW+1)'(rbPush) - (PW+1)'(rbPop);
		end
	end

	logic done;
	logic launch;
	logic cmdWr;
	assign done = cycOn_reg & ~hbus.transferAckN;
	assign cmdWr = regWrStb & (regAddr == `HREG_CMD);

	always_comb begin
		step_next = step_reg;
		cycOn_next = cycOn_reg;
		granted_next = granted_reg;
		error_next = error_reg;
		memRead_next = memRead_reg;
		mAddr_next = mAddr_reg;
		wData_next = wData_reg;
		hAddr_next = hAddr_reg;
		hRw_next = hRw_reg;
		hAsN_next = hAsN_reg;
		hData_next = hData_reg;
		hDataOe_next = hDataOe_reg;
		rdData_next = rdData_reg;
		rbPush = 1'b0;
		launch = 1'b0;
		if (regWrStb && regAddr == `HREG_MADDR) begin
			mAddr_next = regWrData[13:0];
		end
		if (regWrStb && regAddr == `HREG_WDATA) begin
			wData_next = regWrData;
		end
		if (regWrStb && regAddr == `HREG_STATUS) begin
			error_next = 1'b0;
		end
		case (step_reg)
			STEP_IDLE: begin
				if (cmdWr) begin
					case (regWrData[1:0])
						`CMD_ACQUIRE: begin
							if (granted_reg) error_next = 1'b1;
							else step_next = STEP_SETREQ;
						end
						`CMD_RELEASE: begin
							if (!granted_reg) error_next = 1'b1;
							else step_next = STEP_CLREN;
						end
						default: begin
							if (!granted_reg) begin
								error_next = 1'b1;
							end else begin
								step_next = STEP_MEM;
								memRead_next = (regWrData[1:0] == `CMD_MEM_READ);
							end
						end
					endcase
				end
			end
			default: begin
				if (cmdWr) error_next = 1'b1;
				if (!cycOn_reg) begin
					launch = !(step_reg == STEP_MEM && memRead_reg && !rbInReady);
					hAddr_next = REG_ADDR;
					hRw_next = 1'b0;
					hData_next = '0;
					case (step_reg)
						STEP_SETREQ: hData_next[`TX_REQ_BIT] = 1'b1;
						STEP_POLLGRANT: hRw_next = 1'b1;
						STEP_SETEN: begin
							hData_next[`TX_REQ_BIT] = 1'b1;
							hData_next[`TX_BUFEN_BIT] = 1'b1;
						end
						STEP_MEM: begin
							hAddr_next = {`BRG_REGION_CODE, 1'b0, mAddr_reg};
							hRw_next = memRead_reg;
							hData_next = wData_reg;
						end
						STEP_CLREN: hData_next[`TX_REQ_BIT] = 1'b1;
						STEP_POLLFREE: hRw_next = 1'b1;
						default: hData_next = '0;
					endcase
					if (launch) begin
						cycOn_next = 1'b1;
						hAsN_next = 1'b0;
						hDataOe_next = ~hRw_next;
					end
					if (step_reg == STEP_CLREN) granted_next = 1'b0;
				end else if (done) begin
					cycOn_next = 1'b0;
					hAsN_next = 1'b1;
					hDataOe_next = 1'b0;
					case (step_reg)
						STEP_SETREQ: step_next = STEP_POLLGRANT;
						STEP_POLLGRANT: begin
							if (!hbus.dataFromDev[`RX_GRANT_BIT]) step_next = STEP_SETEN;
						end
						STEP_SETEN: begin
							step_next = STEP_IDLE;
							granted_next = 1'b1;
						end
						STEP_MEM: begin
							step_next = STEP_IDLE;
							if (memRead_reg) begin
								rbPush = 1'b1;
								rdData_next = hbus.dataFromDev;
							end
						end
						STEP_CLREN: step_next = STEP_CLRREQ;
						STEP_CLRREQ: step_next = STEP_POLLFREE;
						STEP_POLLFREE: begin
							if (hbus.dataFromDev[`RX_GRANT_BIT]) step_next = STEP_IDLE;
						end
						default: step_next = STEP_IDLE;
					endcase
				end
			end
		endcase
		if (regRdStb) begin
			rdData_next = '0;
			if (regAddr == `HREG_RDATA) begin
				rdData_next = rbOutValid ? 16'(rbMem[rbRd_reg]) : 16'h0000;
			end else if (regAddr == `HREG_MADDR) begin
				rdData_next = {2'h0, mAddr_reg};
			end else if (regAddr == `HREG_WDATA) begin
				rdData_next = wData_reg;
			end else if (regAddr == `HREG_STATUS) begin
				rdData_next[`ST_BUSY_BIT] = (step_reg != STEP_IDLE);
				rdData_next[`ST_GRANTED_BIT] = granted_reg;
				rdData_next[`ST_ERROR_BIT] = error_reg;
				rdData_next[`ST_FIFO_LO +: PW+1] = rbCnt_reg;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			step_reg <= STEP_IDLE;
			cycOn_reg <= 1'b0;
			granted_reg <= 1'b0;
			error_reg <= 1'b0;
			memRead_reg <= 1'b0;
			mAddr_reg <= '0;
			wData_reg <= '0;
			hAddr_reg <= '0;
			hRw_reg <= 1'b1;
			hAsN_reg <= 1'b1;
			hData_reg <= '0;
			hDataOe_reg <= 1'b0;
			rdData_reg <= '0;
		end else begin
			step_reg <= step_next;
			cycOn_reg <= cycOn_next;
			granted_reg <= granted_next;
			error_reg <= error_next;
			memRead_reg <= memRead_next;
			mAddr_reg <= mAddr_next;
			wData_reg <= wData_next;
			hAddr_reg <= hAddr_next;
			hRw_reg <= hRw_next;
			hAsN_reg <= hAsN_next;
			hData_reg <= hData_next;
			hDataOe_reg <= hDataOe_next;
			rdData_reg <= rdData_next;
		end
	end

	assign hbus.addr = hAddr_reg;
	assign hbus.readWrite = hRw_reg;
	assign hbus.addrStrobeN = hAsN_reg;
	assign hbus.lowerByteStrobeN = hAsN_reg;
	assign hbus.upperByteStrobeN = hAsN_reg;
	assign hbus.dataToDev = hData_reg;
	assign hbus.dataToDevOe = hDataOe_reg;
	assign regRdData = rdData_reg;

endmodule : host_bus_master

// File: testbench/bridge_bus_chk.sv
// Purpose: Protocol checks on the host bus and the processor memory pins
// Assumes: ACK_WAIT matches the bridge instance
// Notes:   Instantiated beside the interface in tb_top
`timescale 1ns/100ps
module bridge_bus_chk #(
	parameter int ACK_WAIT = 2
) (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic [23:1] addr,
	input wire logic [15:0] dataToDev,
	input wire logic [15:0] dataFromDev,
	input wire logic        dataFromDevOe,
	input wire logic        readWrite,
	input wire logic        addrStrobeN,
	input wire logic        lowerByteStrobeN,
	input wire logic        transferAckN,
	input wire logic        busRequestN,
	input wire logic        busGrantN,
	input wire logic [13:0] dmemAddr,
	input wire logic        dmemAddrOe,
	input wire logic        dmemSelectN,
	input wire logic        dmemWriteStrobeN,
	input wire logic        dmemWriteStrobeOe,
	input wire logic        dmemDataOe
);
	logic       hit;
	logic       grantPrev_reg;
	logic [2:0] grantAge_reg;
	logic [2:0] grantAge_next;

	assign hit = addr[23:16] == 8'h02;

	// Cycles since grant last moved, so readback is past the synchroniser
	always_comb begin
		grantAge_next = (busGrantN != grantPrev_reg) ? 3'h0 :
			(grantAge_reg == 3'h7) ? grantAge_reg : grantAge_reg + 3'h1;
	end
	always_ff @(posedge mclk) begin
		grantPrev_reg <= busGrantN;
		grantAge_reg  <= rst ? 3'h0 : grantAge_next;
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_start;
		$fell(addrStrobeN) && hit;
	endsequence
	sequence s_txWrite;
		!transferAckN && !addrStrobeN && !readWrite && addr[15] && !lowerByteStrobeN && hit;
	endsequence
	sequence s_rxRead;
		!transferAckN && !addrStrobeN && readWrite && addr[15] && hit && grantAge_reg > 3'h5;
	endsequence

	a_ack_not_early: assert property (s_start |-> transferAckN)
		else $error("ack on first strobe cycle");
	a_ack_after_wait: assert property (s_start |-> ##ACK_WAIT !transferAckN)
		else $error("ack missing after wait");
	a_ack_only_region: assert property (!transferAckN |-> !addrStrobeN && hit)
		else $error("ack without strobe or region");
	a_request_load: assert property (s_txWrite |-> ##2 busRequestN == !$past(dataToDev[0], 2))
		else $error("request bit not loaded");
	a_bufen_load: assert property (s_txWrite |-> ##2 dmemAddrOe == $past(dataToDev[1], 2))
		else $error("buffer enable not loaded");
	a_grant_readback: assert property (s_rxRead |-> dataFromDevOe && dataFromDev[0] == busGrantN)
		else $error("grant readback wrong");
	a_read_gated: assert property (dataFromDevOe |-> $past(readWrite && !addrStrobeN && hit))
		else $error("read buffer on outside read");
	a_write_dir: assert property (dmemDataOe |-> $past(!readWrite && !addrStrobeN) && !dataFromDevOe)
		else $error("data path direction wrong");
	a_wstrobe_idle: assert property (dmemWriteStrobeOe && !dmemAddrOe |-> dmemWriteStrobeN)
		else $error("write strobe active while buffers off");
	a_mem_map: assert property (!dmemSelectN |->
		dmemAddrOe && $past(!addr[15] && !addrStrobeN) && dmemAddr == $past(addr[14:1]))
		else $error("memory select or address wrong");
	a_reset_clear: assert property (disable iff (1'b0)
		$past(rst) |-> busRequestN && !dmemAddrOe && transferAckN)
		else $error("reset left outputs active");
endmodule : bridge_bus_chk

// File: testbench/tb_top.sv
// Purpose: Host end and bridge end driven from the register port
// Assumes: Processor side modelled here: grant follower and data memory
// Notes:   Row loop for memory traffic, then buffer, release and reset cases
`timescale 1ns/100ps
`include "bridge_consts.svh"
module tb_top import bridge_pkg::*;;
	logic        mclk = 1'b0;
	logic        rst  = 1'b1;
	logic [2:0]  regAddr = 3'h0;
	word_t       regWrData = 16'h0000;
	logic        regWrStb = 1'b0;
	logic        regRdStb = 1'b0;
	word_t       regRdData;
	logic        busRequestN;
	logic        busGrantN = 1'b1;
	logic [13:0] dmemAddr;
	logic        dmemAddrOe, dmemSelectN, dmemWriteStrobeN, dmemWriteStrobeOe, dmemDataOe;
	word_t       dmemDataIn, dmemDataOut;
	word_t       mem [0:16383] = '{default: 16'h5A5A};
	int          n_errors = 0;
	int          checked = 0;
	int          grantLat = 3;
	int          grantCnt = 0;
	logic [13:0] rowA [4] = '{14'h0000, 14'h3FFF, 14'h1555, 14'h2AAA};
	word_t       rowD [4] = '{16'hA5A5, 16'h0001, 16'hFFFF, 16'h8000};

	always #25 mclk = ~mclk;

	host_bus_if hbus ();
	host_bus_master host_bus_master_i (.mclk(mclk), .rst(rst), .hbus(hbus), .regAddr(regAddr),
		.regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData));
	host_dsp_bus_share_bridge #(.ACK_WAIT(2)) host_dsp_bus_share_bridge_i (.mclk(mclk),
		.rst(rst), .hbus(hbus), .busRequestN(busRequestN), .busGrantN(busGrantN),
		.monitorLevels(5'h0A), .dmemAddr(dmemAddr), .dmemAddrOe(dmemAddrOe),
		.dmemSelectN(dmemSelectN), .dmemWriteStrobeN(dmemWriteStrobeN),
		.dmemWriteStrobeOe(dmemWriteStrobeOe), .dmemDataIn(dmemDataIn),
		.dmemDataOut(dmemDataOut), .dmemDataOe(dmemDataOe));
	bridge_bus_chk #(.ACK_WAIT(2)) bridge_bus_chk_i (.mclk(mclk), .rst(rst), .addr(hbus.addr),
		.dataToDev(hbus.dataToDev), .dataFromDev(hbus.dataFromDev),
		.dataFromDevOe(hbus.dataFromDevOe), .readWrite(hbus.readWrite),
		.addrStrobeN(hbus.addrStrobeN), .lowerByteStrobeN(hbus.lowerByteStrobeN),
		.transferAckN(hbus.transferAckN), .busRequestN(busRequestN), .busGrantN(busGrantN),
		.dmemAddr(dmemAddr), .dmemAddrOe(dmemAddrOe), .dmemSelectN(dmemSelectN),
		.dmemWriteStrobeN(dmemWriteStrobeN), .dmemWriteStrobeOe(dmemWriteStrobeOe),
		.dmemDataOe(dmemDataOe));

	// Processor: grant follows request grantLat+1 cycles after the two first differ
	always @(posedge mclk) begin
		if (busGrantN == busRequestN || busRequestN === 1'bx)
			grantCnt <= 0;
		else if (grantCnt >= grantLat) begin
			busGrantN <= busRequestN;
			grantCnt  <= 0;
		end else
			grantCnt <= grantCnt + 1;
		if (dmemAddrOe && !dmemSelectN && !dmemWriteStrobeN)
			mem[dmemAddr] <= dmemDataOut;
	end
	assign dmemDataIn = mem[dmemAddr];

	task automatic chk(input word_t got, input word_t exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic regWr(input logic [2:0] a, input word_t d);
		@(posedge mclk);
		regAddr   <= a;
		regWrData <= d;
		regWrStb  <= 1'b1;
		@(posedge mclk);
		regWrStb <= 1'b0;
	endtask : regWr

	task automatic regRd(input logic [2:0] a, output word_t d);
		@(posedge mclk);
		regAddr  <= a;
		regRdStb <= 1'b1;
		@(posedge mclk);
		regRdStb <= 1'b0;
		@(negedge mclk);
		d = regRdData;
	endtask : regRd

	task automatic waitIdle(output word_t st);
		for (int i = 0; i < 300; i++) begin
			regRd(`HREG_STATUS, st);
			if (st[`ST_BUSY_BIT] === 1'b0)
				return;
		end
		n_errors++;
		$display("Error at %0t: busy stuck", $time);
	endtask : waitIdle

	task automatic cmd(input logic [1:0] c);
		word_t st;
		regWr(`HREG_CMD, {14'h0000, c});
		waitIdle(st);
	endtask : cmd

	task automatic wrap_up;
		$display("Checks %0d, errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up

	initial begin
		word_t st;
		word_t rd;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		// Memory access refused before grant
		cmd(`CMD_MEM_READ);
		regRd(`HREG_STATUS, st);
		chk(16'(st[2:0]), 16'h0004);
		regWr(`HREG_STATUS, 16'h0000);
		grantLat = 12;
		cmd(`CMD_ACQUIRE);
		regRd(`HREG_STATUS, st);
		chk(16'(st[2:0]), 16'h0002);
		chk(16'({busRequestN, busGrantN, dmemAddrOe}), 16'h0001);
		for (int k = 0; k < 4; k++) begin
			regWr(`HREG_MADDR, {2'b00, rowA[k]});
			regWr(`HREG_WDATA, rowD[k]);
			cmd(`CMD_MEM_WRITE);
			chk(mem[rowA[k]], rowD[k]);
			cmd(`CMD_MEM_READ);
			regRd(`HREG_RDATA, rd);
			chk(rd, rowD[k]);
		end
		// Fill the read buffer, third read stalls
		for (int k = 0; k < 3; k++) begin
			regWr(`HREG_MADDR, {2'b00, rowA[k]});
			regWr(`HREG_CMD, {14'h0000, `CMD_MEM_READ});
			if (k < 2)
				waitIdle(st);
		end
		repeat (20) @(posedge mclk);
		regRd(`HREG_STATUS, st);
		chk(16'(st[4:0]), 16'h0013);
		for (int k = 0; k < 3; k++) begin
			if (k == 2)
				waitIdle(st);
			regRd(`HREG_RDATA, rd);
			chk(rd, rowD[k]);
		end
		regRd(`HREG_RDATA, rd);
		chk(rd, 16'h0000);
		cmd(`CMD_RELEASE);
		regRd(`HREG_STATUS, st);
		chk(16'(st[2:0]), 16'h0000);
		chk(16'({busRequestN, busGrantN, dmemAddrOe, dmemWriteStrobeN}), 16'h000D);
		// Second release refused while not granted
		cmd(`CMD_RELEASE);
		regRd(`HREG_STATUS, st);
		chk(16'(st[2:0]), 16'h0004);
		regWr(`HREG_STATUS, 16'h0000);
		// Reset in mid-run while granted
		cmd(`CMD_ACQUIRE);
		@(posedge mclk);
		rst <= 1'b1;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		@(negedge mclk);
		chk(16'({busRequestN, dmemAddrOe}), 16'h0002);
		repeat (30) @(posedge mclk);
		wrap_up();
	end

	initial begin
		#2000000;
		n_errors++;
		$display("Error at %0t: timeout", $time);
		wrap_up();
	end
endmodule : tb_top
